/* File: rtl/brmc_core.sv */
// burst / restart mode control: sequences light-load burst, blanking and auto restart
// assumes comparator and supply flags are synchronous; rst_i is the under-voltage reset
`timescale 1ns/10ps
// How it works
// - 20 ms blanking before burst or restart
// - overload counts 20 ms then releases clamp
// - restart gate waits for pin 4.0V
// - 30 us spike blanking before restart
// - burst fixed blanking; restart fixed plus extension
// - burst counter held zero, counts below 1.35V
// - burst entry when expired and still low
// - burst sets flag, bias off
// - startup cell off during burst
// - above 3.5V in burst: bias on
// - burst selects reduced 0.34V limit
// - below 3.0V in burst: bias off
// - above 4.0V in burst: leave burst
// - all listed faults lead to restart
// - only overload blanked; others immediate
// - restart: off, charge, power up, soft start
// - after startup recheck fault
// - soft start completes within 20 ms
module brmc_core
  import brmc_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES     = BLANK_CYC,
  parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC,
  parameter int unsigned SPIKE_CYCLES     = SPIKE_CYC
)
(
  // clock and reset
  input  wire logic      clock_i,
  input  wire logic      rst_i,
  // analog decisions
  input  wire brmc_cmp_t cmp_i,
  input  wire brmc_sup_t sup_i,
  // control outputs
  output logic           bias_en_o,
  output logic           burst_flag_o,
  output logic           reduced_limit_o,
  output logic           clamp_release_o,
  output logic           startup_cell_on_o,
  output logic           soft_start_o,
  output logic           restart_active_o
);

  // ==========================================================
  // state
  // ==========================================================
  brmc_state_t      state;
  brmc_state_t      next_state;
  logic             burst_done;
  logic             ovl_done;
  logic             spike_done;
  logic             ss_done;
  logic             burst_run;
  logic             ovl_run;
  logic             spike_run;
  logic             ss_run;
  logic             fast_fault;
  logic             trigger_gate;

  assign fast_fault = sup_i.vcc_ovp | sup_i.over_temp | sup_i.ext_restart | sup_i.vcc_off;

  // ==========================================================
  // mode entry conditions
  // ==========================================================
  logic             enter_restart;
  logic             enter_burst;
  logic             leave_burst;
  logic             recheck_fail;

  // overload reaches restart only through both blanking stages
  assign enter_restart = fast_fault || spike_done;
  // burst needs the expired counter and the feedback still low
  assign enter_burst   = burst_done && cmp_i.fb_below_1v35;
  // a heavy load jump ends burst at once
  assign leave_burst   = cmp_i.fb_above_4v0;
  // after soft start a feedback still high means the fault persists
  assign recheck_fail  = cmp_i.fb_above_4v0;

  // ==========================================================
  // blanking and soft start timers
  // ==========================================================
  assign burst_run = (state == BRMC_NORMAL) && cmp_i.fb_below_1v35;
  assign ovl_run   = (state == BRMC_NORMAL || state == BRMC_BURST) && cmp_i.fb_above_4v0;
  assign trigger_gate = ovl_done && cmp_i.pin_at_4v0;
  assign spike_run = trigger_gate;
  assign ss_run    = (state == BRMC_SOFTSTART);

  brmc_timer #(.LIMIT(BLANK_CYCLES)) u_burst_timer
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (burst_run),
    .done_o  (burst_done)
  );

  brmc_timer #(.LIMIT(BLANK_CYCLES)) u_ovl_timer
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (ovl_run),
    .done_o  (ovl_done)
  );

  brmc_timer #(.LIMIT(SPIKE_CYCLES)) u_spike_timer
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (spike_run),
    .done_o  (spike_done)
  );

  brmc_timer #(.LIMIT(SOFTSTART_CYCLES)) u_ss_timer
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (ss_run),
    .done_o  (ss_done)
  );

  // ==========================================================
  // mode sequencing
  // ==========================================================
  always_comb
  begin
    next_state = state;
    case (state)
      BRMC_NORMAL:
      begin
        if (enter_restart)
          next_state = BRMC_RESTART_OFF;
        else if (enter_burst)
          next_state = BRMC_BURST;
      end
      BRMC_BURST:
      begin
        if (fast_fault)
          next_state = BRMC_RESTART_OFF;
        else if (leave_burst)
          next_state = BRMC_NORMAL;
      end
      BRMC_RESTART_OFF:
      begin
        if (sup_i.vcc_off)
          next_state = BRMC_RESTART_CHARGE;
      end
      BRMC_RESTART_CHARGE:
      begin
        if (sup_i.vcc_on)
          next_state = BRMC_SOFTSTART;
      end
      BRMC_SOFTSTART:
      begin
        if (fast_fault)
          next_state = BRMC_RESTART_OFF;
        else if (ss_done)
          next_state = recheck_fail ? BRMC_RESTART_OFF : BRMC_NORMAL;
      end
      default:
        next_state = BRMC_NORMAL;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      state <= BRMC_NORMAL;
    else
      state <= next_state;
  end

  // ==========================================================
  // burst bias hysteresis
  // ==========================================================
  logic burst_bias;
  logic next_burst_bias;
  logic stay_burst;

  // bias stays off on the entry edge, then follows the burst comparators
  assign stay_burst = (state == BRMC_BURST) && (next_state == BRMC_BURST);

  always_comb
  begin
    next_burst_bias = burst_bias;
    if (!stay_burst)
      next_burst_bias = 1'b0;
    else if (cmp_i.fb_above_3v5)
      next_burst_bias = 1'b1;
    else if (cmp_i.fb_below_3v0)
      next_burst_bias = 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      burst_bias <= 1'b0;
    else
      burst_bias <= next_burst_bias;
  end

  // ==========================================================
  // next mode decodes
  // ==========================================================
  logic next_is_normal;
  logic next_is_burst;
  logic next_is_off;
  logic next_is_charge;
  logic next_is_soft;

  // outputs follow the mode they enter, so they change on the same edge
  assign next_is_normal = (next_state == BRMC_NORMAL);
  assign next_is_burst  = (next_state == BRMC_BURST);
  assign next_is_off    = (next_state == BRMC_RESTART_OFF);
  assign next_is_charge = (next_state == BRMC_RESTART_CHARGE);
  assign next_is_soft   = (next_state == BRMC_SOFTSTART);

  // ==========================================================
  // internal bias enable
  // ==========================================================
  // bias runs in normal mode and soft start, is gated in burst, off in restart
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      bias_en_o <= 1'b1;
    else if (next_is_normal || next_is_soft)
      bias_en_o <= 1'b1;
    else if (next_is_burst)
      bias_en_o <= next_burst_bias;
    else
      bias_en_o <= 1'b0;
  end

  // ==========================================================
  // burst flag and reduced current limit
  // ==========================================================
  // the flag marks burst mode through the whole sawtooth
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      burst_flag_o <= 1'b0;
    else
      burst_flag_o <= next_is_burst;
  end

  // the reduced limit drops with the flag, restoring the full limit
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      reduced_limit_o <= 1'b0;
    else
      reduced_limit_o <= next_is_burst;
  end

  // ==========================================================
  // blanking pin clamp
  // ==========================================================
  logic clamp_window;

  // released only while switching, so the pin can charge toward restart
  assign clamp_window = next_is_normal || next_is_burst;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      clamp_release_o <= 1'b0;
    else
      clamp_release_o <= ovl_done && clamp_window;
  end

  // ==========================================================
  // restart sequence outputs
  // ==========================================================
  // startup cell only charges the supply in restart, never in burst
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      startup_cell_on_o <= 1'b0;
    else
      startup_cell_on_o <= next_is_charge;
  end

  // soft start covers one fixed-length startup phase
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      soft_start_o <= 1'b0;
    else
      soft_start_o <= next_is_soft;
  end

  // restart covers the off and charging phases
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      restart_active_o <= 1'b0;
    else
      restart_active_o <= next_is_off || next_is_charge;
  end

endmodule

/* File: rtl/brmc_pkg.sv */
// constants and carrier types for the burst / restart mode control unit
// assumes a single 10 MHz clock; all comparator inputs synchronous to it
package brmc_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BLANK_MS        = 20;
  localparam int unsigned SPIKE_US        = 30;
  localparam int unsigned SOFTSTART_MS    = 20;
  localparam int unsigned BLANK_CYC       = (CLK_HZ / 1000) * BLANK_MS;
  localparam int unsigned SPIKE_CYC       = (CLK_HZ / 1000000) * SPIKE_US;
  localparam int unsigned SOFTSTART_CYC   = (CLK_HZ / 1000) * SOFTSTART_MS;
  localparam int unsigned CNT_W           = 24;

  // comparator decisions from the analog side
  typedef struct packed {
    logic fb_above_4v0;    // feedback_high_comparator
    logic fb_below_1v35;   // light_load_comparator
    logic fb_above_3v5;    // burst_upper_comparator
    logic fb_below_3v0;    // burst_lower_comparator
    logic pin_at_4v0;      // blanking_pin_comparator
  } brmc_cmp_t;

  // faults that bypass blanking, plus supply thresholds
  typedef struct packed {
    logic vcc_ovp;
    logic over_temp;
    logic ext_restart;
    logic vcc_off;         // supply fell to turn-off threshold
    logic vcc_on;          // supply reached turn-on threshold
  } brmc_sup_t;

  typedef enum logic [2:0] {
    BRMC_NORMAL,
    BRMC_BURST,
    BRMC_RESTART_OFF,
    BRMC_RESTART_CHARGE,
    BRMC_SOFTSTART
  } brmc_state_t;

endpackage

/* File: rtl/brmc_timer.sv */
// blanking timer: counts while enabled, clears when disabled
// assumes enable held for the whole interval
`timescale 1ns/10ps
module brmc_timer
  import brmc_pkg::*;
#(
  parameter int unsigned LIMIT = 16
)
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // control
  input  wire logic run_i,
  output logic      done_o
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      count <= '0;
    else if (!run_i)
      count <= '0;
    else if (count != CNT_W'(LIMIT))
      count <= count + 1'b1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      done_o <= 1'b0;
    else
      done_o <= run_i && (count >= CNT_W'(LIMIT - 1));
  end

endmodule

/* File: tb/brmc_analog_model.sv */
// far side: blanking pin charge and supply thresholds
// follows the core's outputs, drives at the falling edge
`timescale 1ns/10ps
module brmc_analog_model #(
  parameter int EXT = 10
)
(
  // clock and core outputs
  input  wire logic clock_i,
  input  wire logic clamp_i,
  input  wire logic off_i,
  input  wire logic cell_i,
  // analog decisions
  output logic      pin_o     = 1'b0,
  output logic      vcc_off_o = 1'b0,
  output logic      vcc_on_o  = 1'b0
);
  int kp = 0;
  int ks = 0;
  int kc = 0;
  // pin leaves the clamp level only once released
  always @(negedge clock_i)
  begin
    kp <= clamp_i ? kp + 1 : 0;
    pin_o <= clamp_i && kp >= EXT;
    ks <= (off_i && !cell_i) ? ks + 1 : 0;
    vcc_off_o <= off_i && !cell_i && ks >= 4;
    kc <= cell_i ? kc + 1 : 0;
    vcc_on_o <= cell_i && kc >= 6;
  end
endmodule

/* File: tb/brmc_core_assertions.sv */
// checker for the mode control core
// sees the core's ports only; bound below
`timescale 1ns/10ps
module brmc_core_assertions
  import brmc_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = BLANK_CYC
)
(
  input wire logic      clock_i,
  input wire logic      rst_i,
  input wire brmc_cmp_t cmp_i,
  input wire brmc_sup_t sup_i,
  input wire logic      bias_en_o,
  input wire logic      burst_flag_o,
  input wire logic      reduced_limit_o,
  input wire logic      clamp_release_o,
  input wire logic      startup_cell_on_o,
  input wire logic      soft_start_o,
  input wire logic      restart_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  int unsigned lo_cnt;
  int unsigned hi_cnt;
  // run lengths of the qualifying feedback levels
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end
    else
    begin
      lo_cnt <= cmp_i.fb_below_1v35 ? lo_cnt + 1 : 0;
      hi_cnt <= cmp_i.fb_above_4v0 ? hi_cnt + 1 : 0;
    end
  end
  sequence s_up;
    burst_flag_o && cmp_i == 5'h04 && sup_i == 5'h00;
  endsequence
  property p_lim; reduced_limit_o == burst_flag_o; endproperty
  property p_enter; $rose(burst_flag_o) |-> lo_cnt >= BLANK_CYCLES; endproperty
  property p_off; $rose(burst_flag_o) |-> !bias_en_o; endproperty
  property p_cell; burst_flag_o |-> !startup_cell_on_o; endproperty
  property p_up; s_up |=> bias_en_o; endproperty
  property p_dn; burst_flag_o && cmp_i == 5'h02 && sup_i == 5'h00 |=> !bias_en_o && burst_flag_o; endproperty
  property p_leave; burst_flag_o && cmp_i.fb_above_4v0 && sup_i == 5'h00 |=> !burst_flag_o; endproperty
  property p_clamp; $rose(clamp_release_o) |-> hi_cnt >= BLANK_CYCLES - 1; endproperty
  property p_fast; sup_i[4:2] != 3'h0 && !restart_active_o && !startup_cell_on_o |=> restart_active_o; endproperty
  a_lim: assert property (p_lim) else $error("limit select differs from burst");
  a_enter: assert property (p_enter) else $error("burst entered early");
  a_off: assert property (p_off) else $error("bias on at burst entry");
  a_cell: assert property (p_cell) else $error("startup cell on in burst");
  a_up: assert property (p_up) else $error("bias not resumed");
  a_dn: assert property (p_dn) else $error("bias not stopped");
  a_leave: assert property (p_leave) else $error("burst not left");
  a_clamp: assert property (p_clamp) else $error("clamp released early");
  a_fast: assert property (p_fast) else $error("fault not immediate");
endmodule
bind brmc_core brmc_core_assertions #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .cmp_i(cmp_i), .sup_i(sup_i), .bias_en_o(bias_en_o),
  .burst_flag_o(burst_flag_o), .reduced_limit_o(reduced_limit_o), .clamp_release_o(clamp_release_o),
  .startup_cell_on_o(startup_cell_on_o), .soft_start_o(soft_start_o), .restart_active_o(restart_active_o));

/* File: tb/testbench.sv */
// self-checking bench for the mode control core
// levels driven at the falling edge; analog model closes the loops
`timescale 1ns/10ps
module testbench;
  import brmc_pkg::*;
  localparam int BLK = 20;
  localparam int SFT = 30;
  localparam int SPK = 5;
  localparam int EXT = 10;
  logic       clock_i   = 1'b0;
  logic       rst_i     = 1'b1;
  logic [3:0] c         = 4'h0;
  logic [2:0] flt       = 3'h0;
  wire        pin;
  wire        voff;
  wire        von;
  wire  [6:0] outs;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc       = 0;
  int         n;
  brmc_core #(.BLANK_CYCLES(BLK), .SOFTSTART_CYCLES(SFT), .SPIKE_CYCLES(SPK)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .cmp_i({c, pin}), .sup_i({flt, voff, von}),
    .bias_en_o(outs[6]), .burst_flag_o(outs[5]), .reduced_limit_o(outs[4]), .clamp_release_o(outs[3]),
    .startup_cell_on_o(outs[2]), .soft_start_o(outs[1]), .restart_active_o(outs[0]));
  brmc_analog_model #(.EXT(EXT)) far (.clock_i(clock_i), .clamp_i(outs[3]), .off_i(outs[0]),
    .cell_i(outs[2]), .pin_o(pin), .vcc_off_o(voff), .vcc_on_o(von));
  task automatic chk(logic [6:0] m, logic [6:0] e);
    tests_run++;
    if ((outs & m) !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, outs & m, e);
    end
  endtask
  task automatic chk_rng(int v, int lo, int hi);
    tests_run++;
    if (v < lo || v > hi)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge clock_i);
  endtask
  task automatic wait_bit(int i, logic v);
    n = 0;
    while (outs[i] !== v && n < 500)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      give_verdict;
    end
  end
  initial
  begin
    tick(5);
    rst_i = 1'b0;
    chk(7'h7f, 7'h40);
    c = 4'h4;
    tick(BLK - 5);
    c = 4'h0;
    tick(2);
    chk(7'h7f, 7'h40);
    c = 4'h4;
    wait_bit(5, 1'b1);
    chk_rng(n, BLK - 1, BLK + 3);
    tick(1);
    chk(7'h7f, 7'h30);
    c = 4'h2;
    tick(2);
    chk(7'h7f, 7'h70);
    c = 4'h1;
    tick(2);
    chk(7'h7f, 7'h30);
    c = 4'h8;
    tick(2);
    c = 4'h0;
    chk(7'h7f, 7'h40);
    tick(1);
    c = 4'h8;
    wait_bit(3, 1'b1);
    chk_rng(n, BLK - 1, BLK + 3);
    wait_bit(0, 1'b1);
    chk_rng(n, EXT + SPK, EXT + SPK + 5);
    tick(1);
    chk(7'h49, 7'h01);
    wait_bit(2, 1'b1);
    wait_bit(1, 1'b1);
    chk(7'h04, 7'h00);
    wait_bit(1, 1'b0);
    chk_rng(n, SFT - 2, SFT + 2);
    tick(1);
    chk(7'h01, 7'h01);
    c = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        flt = 3'h4 >> (i - 1);
      tick(1);
      chk(7'h01, 7'h01);
      flt = 3'h0;
      wait_bit(1, 1'b1);
      wait_bit(1, 1'b0);
      tick(1);
      chk(7'h7f, 7'h40);
    end
    give_verdict;
  end
endmodule
